// *** rtl/mrpwm_bank.sv ***
// Summary of operation
// - Enable bit picks PWM or port per low pin
// - One polarity bit each, 7-bit and 6-bit groups
// - Low outputs clocked at crystal/3, width=latch
// - 6-bit period 192, 7-bit period 384 clocks
// - Byte outputs enabled individually; absent variant writes zero
// - One polarity bit for all byte outputs
// - Byte outputs at crystal rate, period 256
// - Zero latch: byte output high, low outputs low
// - Wide output drives pin only when enabled
// - Fine and coarse 7-bit latches at 18, 19
// - Fine latch write copies both into working reg
// - Upper bits coarse width, lower bits fine select
// - Coarse OR fine, polarity bit at 23
// - Wide counter at crystal/3, subperiod 384 clocks
// - Coarse low for value+1 steps, then high
// - Fine pulse one step at subperiod start
// - Zero bits select subperiods, union of sets
// - Bit k selects odd multiples of 2^(6-k)
// - All ones adds no fine pulses
// - Coarse low one step longer than 7-bit wave is high
`timescale 1ns/1ps
`default_nettype none

module mrpwm_bank
    import mrpwm_pkg::*;
(
    // Clock and reset
    input  wire logic           clock_i,
    input  wire logic           rst_i,
    // APB slave
    input  wire mrpwm_apb_req_s apb_i,
    output mrpwm_apb_rsp_s      apb_o,
    // Port line values used when a pin is not in PWM use
    input  wire logic [7:0]     low_port_i,
    input  wire logic [3:0]     byte_port_i,
    input  wire logic           wide_port_i,
    // Shared pins
    output logic [7:0]          low_pin_o,
    output logic [3:0]          byte_pin_o,
    output logic                wide_pin_o
);

    localparam logic [1:0]  PRE_LAST   = 2'(PRESCALE - 1);
    localparam logic [6:0]  SEVEN_LAST = 7'(SEVEN_STEPS - 1);
    localparam logic [13:0] WIDE_LAST  = 14'(WIDE_STEPS - 1);

    // Prescaler and counters
    logic [1:0]  pre_r;
    logic        step;
    logic [6:0]  low_count_r;
    logic [7:0]  byte_count_r;
    logic [13:0] wide_count_r;

    // Registers
    logic [6:0]  low_data_r [8];
    logic [7:0]  byte_data_r [4];
    logic [7:0]  low_res_enable_reg_r;
    logic [3:0]  byte_res_enable_reg_r;
    logic [2:0]  second_control_reg_r;
    logic [6:0]  fine_select_latch_r;
    logic [6:0]  coarse_width_latch_r;
    logic [13:0] fourteen_bit_working_reg_r;
    logic        fourteen_bit_enable_r;
    logic        wide_pol_r;

    // Wide output parts
    logic [6:0]  position;
    logic [6:0]  subperiod;
    logic        coarse_out;
    logic        fine_out;
    logic        coarse_out_r;
    logic        fine_out_r;
    logic        fourteen_bit_output;

    // Bus
    logic [7:0]  idx;
    logic        setup_access;
    logic        wr_commit;
    logic        hit;
    logic [31:0] rdata_nxt;

    function automatic logic fine_hit(input logic [6:0] sel_n,
                                      input logic [6:0] sub);
        logic       hit_v;
        logic [6:0] low_mask;
        hit_v    = 1'b0;
        low_mask = 7'h00;
        for (int k = 0; k < 7; k++) begin
            low_mask = (7'h01 << (6 - k)) - 7'h01;
            // Bit k zero: subperiods that are odd multiples of 2^(6-k)
            if (!sel_n[k] && sub[6 - k]
                && ((sub & low_mask) == 7'h00)) begin
                hit_v = 1'b1;
            end
        end
        return hit_v;
    endfunction

    // Crystal/3 step
    // One shared step keeps every slow counter in phase with the others
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pre_r <= 2'h0;
        end else if (pre_r == PRE_LAST) begin
            pre_r <= 2'h0;
        end else begin
            pre_r <= pre_r + 2'h1;
        end
    end

    assign step = (pre_r == PRE_LAST);

    // Low-resolution counter; the 6-bit group uses its low bits
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            low_count_r <= 7'h00;
        end else if (step) begin
            if (low_count_r == SEVEN_LAST) begin
                low_count_r <= 7'h00;
            end else begin
                low_count_r <= low_count_r + 7'h01;
            end
        end
    end

    // Byte counter, every crystal clock
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            byte_count_r <= 8'h00;
        end else begin
            byte_count_r <= byte_count_r + 8'h01;
        end
    end

    // Wide counter
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wide_count_r <= 14'h0000;
        end else if (step) begin
            if (wide_count_r == WIDE_LAST) begin
                wide_count_r <= 14'h0000;
            end else begin
                wide_count_r <= wide_count_r + 14'h0001;
            end
        end
    end

    // Bus decode
    assign idx          = apb_i.paddr[9:2];
    assign setup_access = apb_i.psel & apb_i.penable & ~apb_o.pready;
    assign wr_commit    = apb_i.psel & apb_i.penable & apb_o.pready
                          & apb_i.pwrite & ~apb_o.pslverr;

    always_comb begin
        hit       = 1'b1;
        rdata_nxt = 32'h0000_0000;
        if (idx < IDX_BYTE_DATA0) begin
            rdata_nxt[6:0] = low_data_r[idx[2:0]];
        end else if (idx < IDX_LOW_EN) begin
            rdata_nxt[7:0] = byte_data_r[idx[1:0]];
        end else begin
            case (idx)
                IDX_LOW_EN:   rdata_nxt[7:0]  = low_res_enable_reg_r;
                IDX_BYTE_EN:  rdata_nxt[3:0]  = byte_res_enable_reg_r;
                IDX_CTRL2:    rdata_nxt[2:0]  = second_control_reg_r;
                IDX_WORK:     rdata_nxt[13:0] = fourteen_bit_working_reg_r;
                IDX_POSITION: rdata_nxt[13:0] = wide_count_r;
                IDX_FINE:     rdata_nxt[6:0]  = fine_select_latch_r;
                IDX_COARSE:   rdata_nxt[6:0]  = coarse_width_latch_r;
                IDX_WIDE_EN:  rdata_nxt[WIDE_EN_BIT] = fourteen_bit_enable_r;
                IDX_WIDE_POL: rdata_nxt[WIDE_POL_BIT] = wide_pol_r;
                default:      hit = 1'b0;
            endcase
        end
    end

    // One wait state; answer is registered so outputs come from flops
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            apb_o <= '0;
        end else begin
            apb_o.pready <= setup_access;
            if (setup_access) begin
                apb_o.pslverr <= ~hit;
                apb_o.prdata  <= apb_i.pwrite ? 32'h0000_0000 : rdata_nxt;
            end else begin
                apb_o.pslverr <= 1'b0;
            end
        end
    end

    // Duty latches of the low and byte outputs
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < 8; i++) begin
                low_data_r[i] <= LOW_DATA_RST;
            end
            for (int i = 0; i < 4; i++) begin
                byte_data_r[i] <= BYTE_DATA_RST;
            end
        end else if (wr_commit) begin
            if (idx < IDX_BYTE_DATA0) begin
                low_data_r[idx[2:0]] <= apb_i.pwdata[6:0];
            end else if (idx < IDX_LOW_EN) begin
                byte_data_r[idx[1:0]] <= apb_i.pwdata[7:0];
            end
        end
    end

    // Enables and polarity
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            low_res_enable_reg_r  <= 8'h00;
            byte_res_enable_reg_r <= 4'h0;
            fourteen_bit_enable_r <= 1'b0;
            second_control_reg_r  <= CTRL2_RST;
            wide_pol_r            <= 1'b0;
        end else if (wr_commit) begin
            case (idx)
                IDX_LOW_EN:   low_res_enable_reg_r  <= apb_i.pwdata[7:0];
                IDX_BYTE_EN:  byte_res_enable_reg_r <= apb_i.pwdata[3:0];
                IDX_CTRL2:    second_control_reg_r  <= apb_i.pwdata[2:0];
                IDX_WIDE_EN:  fourteen_bit_enable_r <=
                                  apb_i.pwdata[WIDE_EN_BIT];
                IDX_WIDE_POL: wide_pol_r <= apb_i.pwdata[WIDE_POL_BIT];
                default:      ;
            endcase
        end
    end

    // Coarse is staged; the fine write moves both together
    // A fine write ahead of the coarse write loads the old coarse width
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            fine_select_latch_r        <= FINE_RST;
            coarse_width_latch_r       <= COARSE_RST;
            fourteen_bit_working_reg_r <= {COARSE_RST, FINE_RST};
        end else if (wr_commit) begin
            if (idx == IDX_COARSE) begin
                coarse_width_latch_r <= apb_i.pwdata[6:0];
            end
            if (idx == IDX_FINE) begin
                fine_select_latch_r        <= apb_i.pwdata[6:0];
                fourteen_bit_working_reg_r <= {coarse_width_latch_r,
                                               apb_i.pwdata[6:0]};
            end
        end
    end

    // Wide output
    assign position  = wide_count_r[6:0];
    assign subperiod = wide_count_r[13:7];

    // Low for value+1 steps, high for the rest of the subperiod
    assign coarse_out = (position >
                         fourteen_bit_working_reg_r[13:7]);

    // All ones gives no hit, so coarse alone remains
    assign fine_out = (position == 7'h00)
                      && fine_hit(fourteen_bit_working_reg_r[6:0],
                                  subperiod);

    // Both controllers flopped alike, so the OR sees aligned edges
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            coarse_out_r <= 1'b0;
            fine_out_r   <= 1'b0;
        end else begin
            coarse_out_r <= coarse_out;
            fine_out_r   <= fine_out;
        end
    end

    // Polarity after the mixer; the pin lags the counter by two clocks
    assign fourteen_bit_output = (coarse_out_r | fine_out_r)
                                 ^ wide_pol_r;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wide_pin_o <= 1'b0;
        end else if (fourteen_bit_enable_r) begin
            wide_pin_o <= fourteen_bit_output;
        end else begin
            wide_pin_o <= wide_port_i;
        end
    end

    // Low-resolution outputs: 7-bit group then 6-bit group
    for (genvar g = 0; g < 4; g++) begin : g_seven
        mrpwm_chan #(
            .W (7)
        ) u_chan (
            .clock_i     (clock_i),
            .rst_i       (rst_i),
            .count_i     (low_count_r),
            .duty_i      (low_data_r[g]),
            .zero_high_i (1'b0),
            .invert_i    (second_control_reg_r[CTRL_SEVEN_POL]),
            .enable_i    (low_res_enable_reg_r[g]),
            .port_i      (low_port_i[g]),
            .pin_o       (low_pin_o[g])
        );
    end

    for (genvar g = 4; g < 8; g++) begin : g_six
        mrpwm_chan #(
            .W (6)
        ) u_chan (
            .clock_i     (clock_i),
            .rst_i       (rst_i),
            .count_i     (low_count_r[5:0]),
            .duty_i      (low_data_r[g][5:0]),
            .zero_high_i (1'b0),
            .invert_i    (second_control_reg_r[CTRL_SIX_POL]),
            .enable_i    (low_res_enable_reg_r[g]),
            .port_i      (low_port_i[g]),
            .pin_o       (low_pin_o[g])
        );
    end

    // Byte outputs; a variant without them keeps the enables at zero
    for (genvar g = 0; g < 4; g++) begin : g_byte
        mrpwm_chan #(
            .W (8)
        ) u_chan (
            .clock_i     (clock_i),
            .rst_i       (rst_i),
            .count_i     (byte_count_r),
            .duty_i      (byte_data_r[g]),
            .zero_high_i (1'b1),
            .invert_i    (second_control_reg_r[CTRL_WIDE_POL]),
            .enable_i    (byte_res_enable_reg_r[g]),
            .port_i      (byte_port_i[g]),
            .pin_o       (byte_pin_o[g])
        );
    end

endmodule // mrpwm_bank

`default_nettype wire

// *** rtl/mrpwm_pkg.sv ***
package mrpwm_pkg;

    // Bus geometry
    localparam int          APB_AW          = 10;
    localparam int          APB_DW          = 32;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_LOW_DATA0   = 8'h00;
    localparam logic [7:0]  IDX_BYTE_DATA0  = 8'h08;
    localparam logic [7:0]  IDX_LOW_EN      = 8'h0C;
    localparam logic [7:0]  IDX_BYTE_EN     = 8'h0D;
    localparam logic [7:0]  IDX_CTRL2       = 8'h0E;
    localparam logic [7:0]  IDX_WORK        = 8'h0F;
    localparam logic [7:0]  IDX_POSITION    = 8'h10;
    localparam logic [7:0]  IDX_FINE        = 8'h18;
    localparam logic [7:0]  IDX_COARSE      = 8'h19;
    localparam logic [7:0]  IDX_WIDE_EN     = 8'h22;
    localparam logic [7:0]  IDX_WIDE_POL    = 8'h23;

    // Field positions
    localparam int          CTRL_SIX_POL    = 0;
    localparam int          CTRL_SEVEN_POL  = 1;
    localparam int          CTRL_WIDE_POL   = 2;
    localparam int          WIDE_EN_BIT     = 0;
    localparam int          WIDE_POL_BIT    = 0;

    // Reset values
    localparam logic [6:0]  FINE_RST        = 7'h7F;
    localparam logic [6:0]  COARSE_RST      = 7'h00;
    localparam logic [6:0]  LOW_DATA_RST    = 7'h00;
    localparam logic [7:0]  BYTE_DATA_RST   = 8'h00;
    localparam logic [2:0]  CTRL2_RST       = 3'h0;

    // Timing, in crystal clocks
    localparam int          PRESCALE        = 3;
    localparam int          SIX_PERIOD_XTAL = 192;
    localparam int          SEVEN_PERIOD_XTAL = 384;
    localparam int          BYTE_PERIOD_XTAL = 256;
    localparam int          SUB_PERIOD_XTAL = 384;
    localparam int          FINE_CYCLE_XTAL = 49152;

    // Derived step counts of the counters
    localparam int          SIX_STEPS       = SIX_PERIOD_XTAL / PRESCALE;
    localparam int          SEVEN_STEPS     = SEVEN_PERIOD_XTAL / PRESCALE;
    localparam int          BYTE_STEPS      = BYTE_PERIOD_XTAL;
    localparam int          WIDE_STEPS      = FINE_CYCLE_XTAL / PRESCALE;
    localparam int          SUB_STEPS       = SUB_PERIOD_XTAL / PRESCALE;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [APB_AW-1:0] paddr;
        logic [APB_DW-1:0] pwdata;
    } mrpwm_apb_req_s;

    typedef struct packed {
        logic [APB_DW-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } mrpwm_apb_rsp_s;

endpackage

// *** rtl/mrpwm_chan.sv ***
`timescale 1ns/1ps
`default_nettype none

module mrpwm_chan
    import mrpwm_pkg::*;
#(
    parameter int W = 7
) (
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    // Shared counter and settings
    input  wire logic [W-1:0] count_i,
    input  wire logic [W-1:0] duty_i,
    input  wire logic         zero_high_i,
    input  wire logic         invert_i,
    input  wire logic         enable_i,
    // Port line value when not in PWM use
    input  wire logic         port_i,
    output logic              pin_o
);

    logic active;

    // Zero duty is a constant level, not a one-step glitch
    always_comb begin
        if (duty_i == '0) begin
            active = zero_high_i;
        end else begin
            active = (count_i < duty_i);
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pin_o <= 1'b0;
        end else if (enable_i) begin
            pin_o <= active ^ invert_i;
        end else begin
            pin_o <= port_i;
        end
    end

endmodule // mrpwm_chan

`default_nettype wire

// *** bench/mrpwm_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

module mrpwm_monitor
    import mrpwm_pkg::*;
(
    // Clock and reset
    input  wire logic           clock_i,
    input  wire logic           rst_i,
    // Bus
    input  wire mrpwm_apb_req_s apb_i,
    input  wire mrpwm_apb_rsp_s apb_o,
    // Pins
    input  wire logic [7:0]     low_port_i,
    input  wire logic [3:0]     byte_port_i,
    input  wire logic           wide_port_i,
    input  wire logic [7:0]     low_pin_o,
    input  wire logic [3:0]     byte_pin_o,
    input  wire logic           wide_pin_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    logic [7:0]  idx_w;
    logic        map_w;
    logic        wr_w;
    logic [7:0]  len_r;
    logic [3:0]  ben_r;
    logic        wen_r;
    logic [6:0]  crs_r;
    logic [13:0] wrk_r;

    assign idx_w = apb_i.paddr[9:2];
    assign map_w = idx_w <= IDX_POSITION || idx_w == IDX_FINE
                || idx_w == IDX_COARSE || idx_w == IDX_WIDE_EN
                || idx_w == IDX_WIDE_POL;
    assign wr_w  = apb_o.pready && apb_i.pwrite && map_w;

    // Shadow of what software wrote, so pin checks know the enables
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            len_r <= 8'h00;
            ben_r <= 4'h0;
            wen_r <= 1'b0;
            crs_r <= COARSE_RST;
            wrk_r <= {COARSE_RST, FINE_RST};
        end else if (wr_w) begin
            case (idx_w)
                IDX_LOW_EN:  len_r <= apb_i.pwdata[7:0];
                IDX_BYTE_EN: ben_r <= apb_i.pwdata[3:0];
                IDX_WIDE_EN: wen_r <= apb_i.pwdata[WIDE_EN_BIT];
                IDX_COARSE:  crs_r <= apb_i.pwdata[6:0];
                IDX_FINE:    wrk_r <= {crs_r, apb_i.pwdata[6:0]};
                default:     ;
            endcase
        end
    end

    a_low_port_pass: assert property (!$past(rst_i) |->
        ((low_pin_o ^ $past(low_port_i)) & ~len_r & ~$past(len_r)) == 8'h00)
        else $error("low pin left its port value");
    a_byte_port_pass: assert property (!$past(rst_i) |->
        ((byte_pin_o ^ $past(byte_port_i)) & ~ben_r & ~$past(ben_r)) == 4'h0)
        else $error("byte pin left its port value");
    a_wide_port_pass: assert property (!$past(rst_i) && !wen_r
        && !$past(wen_r) |-> wide_pin_o == $past(wide_port_i))
        else $error("wide pin left its port value");
    a_one_wait_state: assert property ($rose(apb_i.penable) |->
        !apb_o.pready ##1 apb_o.pready)
        else $error("bus answer not after one wait state");
    a_err_unmapped: assert property (apb_o.pready |->
        apb_o.pslverr == !map_w)
        else $error("error response wrong for address");
    a_work_readback: assert property (apb_o.pready && !apb_i.pwrite
        && idx_w == IDX_WORK |-> apb_o.prdata == {18'h00000, wrk_r})
        else $error("working register not loaded by fine write");
    a_coarse_readback: assert property (apb_o.pready && !apb_i.pwrite
        && idx_w == IDX_COARSE |-> apb_o.prdata == {25'h0000000, crs_r})
        else $error("coarse latch read back wrong");
    a_reset_pins: assert property ($fell(rst_i) |->
        low_pin_o == 8'h00 && byte_pin_o == 4'h0 && !wide_pin_o)
        else $error("pins not cleared by reset");
endmodule // mrpwm_monitor

bind mrpwm_bank mrpwm_monitor u_mon (
    .clock_i, .rst_i, .apb_i, .apb_o, .low_port_i, .byte_port_i,
    .wide_port_i, .low_pin_o, .byte_pin_o, .wide_pin_o
);

`default_nettype wire

// *** bench/mrpwm_filter.sv ***
`timescale 1ns/1ps
`default_nettype none

module mrpwm_filter (
    // Clock and control
    input  wire logic   clock_i,
    input  wire logic   clear_i,
    // Integrated pin
    input  wire logic   pin_i,
    output logic [15:0] charge_o
);
    // Charge counts high clocks; the RC network only sees the average
    always_ff @(posedge clock_i) begin
        if (clear_i) begin
            charge_o <= 16'h0000;
        end else begin
            charge_o <= charge_o + {15'h0000, pin_i};
        end
    end
endmodule // mrpwm_filter

`default_nettype wire

// *** bench/mrpwm_bank_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module mrpwm_bank_bench
    import mrpwm_pkg::*;
;
    logic           clock_i;
    logic           rst_i;
    mrpwm_apb_req_s apb_q;
    mrpwm_apb_rsp_s apb_o;
    logic [7:0]     low_port_q;
    logic [3:0]     byte_port_q;
    logic           wide_port_q;
    logic [7:0]     low_pin_o;
    logic [3:0]     byte_pin_o;
    logic           wide_pin_o;
    logic           clr_q;
    logic [3:0]     taps;
    logic [15:0]    chg [4];
    logic [31:0]    rd;
    logic           er;
    int             e [4];
    int             err_count = 0;
    int             cmp_count = 0;
    int             cyc = 0;
    logic [7:0]     dv [4] = '{8'h00, 8'h01, 8'h25, 8'h3F};

    mrpwm_bank u_dut (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .apb_i       (apb_q),
        .apb_o       (apb_o),
        .low_port_i  (low_port_q),
        .byte_port_i (byte_port_q),
        .wide_port_i (wide_port_q),
        .low_pin_o   (low_pin_o),
        .byte_pin_o  (byte_pin_o),
        .wide_pin_o  (wide_pin_o)
    );

    assign taps = {wide_pin_o, byte_pin_o[0], low_pin_o[4], low_pin_o[0]};
    for (genvar g = 0; g < 4; g++) begin : g_flt
        mrpwm_filter u_flt (
            .clock_i  (clock_i),
            .clear_i  (clr_q),
            .pin_i    (taps[g]),
            .charge_o (chg[g])
        );
    end

    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            err_count++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Entered just after a rising edge; leaves one idle cycle behind
    task automatic xfer(input logic w, input logic [7:0] idx,
                        input logic [31:0] d);
        apb_q.psel    <= 1'b1;
        apb_q.pwrite  <= w;
        apb_q.paddr   <= {idx, 2'b00};
        apb_q.pwdata  <= d;
        @(posedge clock_i);
        apb_q.penable <= 1'b1;
        do @(posedge clock_i); while (apb_o.pready !== 1'b1);
        rd = apb_o.prdata;
        er = apb_o.pslverr;
        apb_q.psel    <= 1'b0;
        apb_q.penable <= 1'b0;
        @(posedge clock_i);
    endtask

    // Error flag shares bit 31, which no register uses
    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        chk({er, rd[30:0]}, exp);
    endtask

    task automatic soak(input int n);
        clr_q <= 1'b1;
        @(posedge clock_i);
        clr_q <= 1'b0;
        repeat (n + 1) @(posedge clock_i);
    endtask

    initial begin
        rst_i = 1'b1;
        apb_q = '0;
        low_port_q = 8'hA5;
        byte_port_q = 4'h9;
        wide_port_q = 1'b1;
        clr_q = 1'b0;
        repeat (12) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        rchk(IDX_FINE, 32'h7F);
        rchk(IDX_WORK, 32'h7F);
        rchk(8'h30, 32'h8000_0000);
        chk({19'h0, wide_pin_o, byte_pin_o, low_pin_o}, 32'h19A5);
        $display("test reset done");
        xfer(1'b1, IDX_COARSE, 32'h15);
        rchk(IDX_WORK, 32'h7F);
        xfer(1'b1, IDX_FINE, 32'h7A);
        rchk(IDX_WORK, 32'hAFA);
        rchk(IDX_COARSE, 32'h15);
        $display("test latches done");
        xfer(1'b1, IDX_LOW_EN, 32'h11);
        xfer(1'b1, IDX_BYTE_EN, 32'h1);
        xfer(1'b1, IDX_WIDE_EN, 32'h1);
        rchk(IDX_LOW_EN, 32'h11);
        rchk(IDX_BYTE_EN, 32'h1);
        rchk(IDX_WIDE_EN, 32'h1);
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 4; i++) begin
                low_port_q <= ~low_port_q;
                xfer(1'b1, IDX_LOW_DATA0, {24'h0, dv[i]});
                xfer(1'b1, IDX_LOW_DATA0 + 8'h04, {24'h0, dv[i]});
                xfer(1'b1, IDX_BYTE_DATA0, {24'h0, dv[i]});
                xfer(1'b1, IDX_COARSE, {24'h0, dv[i]});
                xfer(1'b1, IDX_FINE, 32'h7F);
                xfer(1'b1, IDX_CTRL2, (p == 1) ? 32'h7 : 32'h0);
                xfer(1'b1, IDX_WIDE_POL, (p == 1) ? 32'h1 : 32'h0);
                repeat (768) @(posedge clock_i);
                soak(768);
                e[0] = 6 * dv[i];
                e[1] = 12 * dv[i];
                e[2] = (dv[i] == 8'h00) ? 768 : 3 * dv[i];
                e[3] = 6 * (127 - dv[i]);
                for (int k = 0; k < 4; k++) begin
                    if (p == 1) begin
                        e[k] = 768 - e[k];
                    end
                end
                chk({16'h0, chg[0]}, e[0]);
                chk({16'h0, chg[1]}, e[1]);
                chk({16'h0, chg[2]}, e[2]);
                chk({16'h0, chg[3]}, e[3]);
            end
        end
        $display("test duty done");
        xfer(1'b1, IDX_WIDE_POL, 32'h0);
        xfer(1'b1, IDX_COARSE, 32'h7F);
        xfer(1'b1, IDX_FINE, 32'h2A);
        repeat (384) @(posedge clock_i);
        soak(FINE_CYCLE_XTAL);
        chk({16'h0, chg[3]}, 32'd255);
        rchk(IDX_CTRL2, 32'h7);
        rchk(IDX_WIDE_POL, 32'h0);
        $display("test fine done");
        results();
    end
endmodule // mrpwm_bank_bench

`default_nettype wire
